// ---- src/wrp_ctrl.sv ----
// wrp_ctrl: wake-up, reset, power state and clock control with apb registers
//
// Summary of operation
// - wake enables at direction register bits 6/7
// - two-bit select plus enables pick pins
// - pin wake only on low level
// - low supply holds system reset until release
// - latch mode straps after init interval
// - software reset bit triggers reset and boot
// - software reset keeps latched chip mode
// - over-temperature detector only when enabled
// - temperature ok high while below hot trip
// - thermal shutdown left only below release temperature
// - lf receiver gives carrier and pattern events
// - power only the blocks the state needs
// - cpu idle gates only the cpu clock
// - low and mid rc never enabled together
// - source select picks any oscillator
// - divider applies to fast rc or crystal
// - mid rc clocks controller, low rc in powerdown
// - wake logic on low-rate tick powers controller
// - power reset clears everything including mode
//
// Chosen here: the address map and register access over APB.
`timescale 1ns/1ns
module wrp_ctrl
	import wrp_pkg::*;
#(
	parameter int LP_DIV  = WRP_LP_DIV,
	parameter int INI_CYC = WRP_INI_CYC
) (
	input  wire logic                 clk_i,
	input  wire logic                 nrst_i,
	// apb slave
	input  wire logic                 psel_i,
	input  wire logic                 penable_i,
	input  wire logic                 pwrite_i,
	input  wire logic [7:0]           paddr_i,
	input  wire logic [31:0]          pwdata_i,
	output logic      [31:0]          prdata_o,
	output logic                      pready_o,
	output logic                      pslverr_o,
	// pins and detectors
	input  wire logic [WRP_NPIN-1:0]  gpio_i,
	input  wire logic                 supply_ok_i,
	input  wire logic                 temp_below_trip_i,
	input  wire logic                 temp_below_release_i,
	input  wire logic                 lf_carrier_i,
	input  wire logic                 lf_pattern_i,
	input  wire logic                 timer_wake_i,
	input  wire logic                 periph_irq_i,
	// reset, power and clock control
	output logic                      sys_rst_n_o,
	output logic                      core_rst_n_o,
	output logic [WRP_PWR_W-1:0]      pwr_en_o,
	output logic                      cpu_clk_en_o,
	output logic                      hot_det_en_o,
	output logic                      lprc_en_o,
	output logic                      midrc_en_o,
	output logic [1:0]                sysclk_sel_o,
	output logic [2:0]                sysclk_div_o,
	output logic [1:0]                chip_mode_o
);
	localparam int NSYNC = WRP_NPIN + 7;

	// wake pin mask from enables and select
	function automatic logic [WRP_NPIN-1:0] wake_mask(input logic en_a, input logic en_b,
	                                                  input logic [1:0] sel);
		logic [WRP_NPIN-1:0] m;
		m = '0;
		if (en_a && en_b)
			m = '1;
		else if (en_a)
			m[sel] = 1'b1;
		else if (en_b)
			m[3'(sel) + 3'd2] = 1'b1;
		return m;
	endfunction

	// blocks powered in each state
	function automatic logic [WRP_PWR_W-1:0] pwr_map(input wrp_state_e st, input logic lf_en);
		logic [WRP_PWR_W-1:0] p;
		p = '0;
		case (st)
			WRP_ST_RUN, WRP_ST_IDLE, WRP_ST_WAKE: p = '1;
			WRP_ST_PDOWN: p[WRP_PD_LF] = lf_en;
			default: p = '0;
		endcase
		return p;
	endfunction

	logic                rst_n;
	logic [NSYNC-1:0]    sync_in;
	logic [NSYNC-1:0]    sync_out;
	logic [WRP_NPIN-1:0] pin_s;
	logic                sup_s;
	logic                tok_s;
	logic                trel_s;
	logic                car_s;
	logic                pat_s;
	logic                tmr_s;
	logic                irq_s;

	logic [7:0]          dir_q;
	logic [5:0]          pull_q;
	logic [1:0]          wsel_q;
	logic [3:0]          pctl_q;
	logic                swrst_q;
	logic [4:0]          clk_q;
	logic [4:0]          cause_q;
	logic [1:0]          mode_q;
	logic                por_q;
	logic [13:0]         ini_cnt_q;
	logic                ini_done_q;
	logic [4:0]          srst_cnt_q;
	logic [13:0]         lp_cnt_q;
	logic                lp_tick;
	logic [5:0]          boot_cnt_q;
	wrp_state_e          state_q;
	wrp_state_e          state_d;
	logic [31:0]         prdata_q;
	logic [31:0]         rdata;
	logic                hit;
	logic                wr;
	logic                setup;
	logic [WRP_NPIN-1:0] pin_wake;
	logic [4:0]          ev;
	logic                wake_ev;
	logic                down_req;

	// reset release through two flops
	wrp_sync2 #(.W(1)) u_rst_sync (
		.clk_i  (clk_i),
		.nrst_i (nrst_i),
		.d_i    (1'b1),
		.q_o    (rst_n)
	);

	// all asynchronous pins and detector levels pass two flops
	assign sync_in = {periph_irq_i, timer_wake_i, lf_pattern_i, lf_carrier_i,
	                  temp_below_release_i, temp_below_trip_i, supply_ok_i, gpio_i};
	wrp_sync2 #(.W(NSYNC)) u_in_sync (
		.clk_i  (clk_i),
		.nrst_i (rst_n),
		.d_i    (sync_in),
		.q_o    (sync_out)
	);
	assign pin_s  = sync_out[WRP_NPIN-1:0];
	assign sup_s  = sync_out[WRP_NPIN];
	assign tok_s  = sync_out[WRP_NPIN+1];
	assign trel_s = sync_out[WRP_NPIN+2];
	assign car_s  = sync_out[WRP_NPIN+3];
	assign pat_s  = sync_out[WRP_NPIN+4];
	assign tmr_s  = sync_out[WRP_NPIN+5];
	assign irq_s  = sync_out[WRP_NPIN+6];

	// apb decode: zero wait states, read data captured in the setup cycle
	assign setup = psel_i && !penable_i;
	assign wr    = psel_i && penable_i && pwrite_i && hit;
	always_comb begin
		hit   = 1'b1;
		rdata = '0;
		case (paddr_i)
			WRP_OFS_DIR:   rdata[7:0] = dir_q;
			WRP_OFS_PULL:  rdata[5:0] = pull_q;
			WRP_OFS_AUX:   rdata[WRP_AUX_SEL_LO +: 2] = wsel_q;
			WRP_OFS_PCTL:  rdata[3:0] = pctl_q;
			WRP_OFS_XCTL:  begin
				rdata[WRP_EP_SWRST] = swrst_q;
				rdata[WRP_EP_TOK] = pctl_q[WRP_PC_THERM] ? tok_s : 1'b1;
				rdata[WRP_EP_MODE_LO +: 2] = mode_q;
			end
			WRP_OFS_CLK:   rdata[4:0] = clk_q;
			WRP_OFS_STAT:  begin
				rdata[2:0] = state_q;
				rdata[WRP_STAT_CAUSE_LO +: 5] = cause_q;
			end
			default:       hit = 1'b0;
		endcase
	end

	assign pready_o  = 1'b1;
	assign pslverr_o = psel_i && penable_i && !hit;
	assign prdata_o  = prdata_q;

	// read data flop
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n)
			prdata_q <= '0;
		else if (setup)
			prdata_q <= rdata;
	end

	// power-on tracking: low supply holds reset and clears the mode latch
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			por_q      <= 1'b0;
			ini_cnt_q  <= '0;
			ini_done_q <= 1'b0;
			mode_q     <= '0;
		end else if (!sup_s) begin
			por_q      <= 1'b0;
			ini_cnt_q  <= '0;
			ini_done_q <= 1'b0;
			mode_q     <= '0;
		end else begin
			por_q <= 1'b1;
			if (!ini_done_q) begin
				if (ini_cnt_q == 14'(INI_CYC - 1)) begin
					ini_done_q <= 1'b1;
					mode_q     <= pin_s[1:0];
				end else
					ini_cnt_q <= ini_cnt_q + 14'd1;
			end
		end
	end
	assign sys_rst_n_o = por_q && ini_done_q;
	assign chip_mode_o = mode_q;

	// software reset pulse; mode latch is untouched here
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			swrst_q    <= 1'b0;
			srst_cnt_q <= '0;
		end else if (!sys_rst_n_o) begin
			swrst_q    <= 1'b0;
			srst_cnt_q <= '0;
		end else if (wr && paddr_i == WRP_OFS_XCTL && pwdata_i[WRP_EP_SWRST]) begin
			swrst_q    <= 1'b1;
			srst_cnt_q <= 5'(WRP_SRST_CYC);
		end else begin
			swrst_q <= 1'b0;
			if (srst_cnt_q != '0)
				srst_cnt_q <= srst_cnt_q - 5'd1;
		end
	end
	assign core_rst_n_o = sys_rst_n_o && !swrst_q && srst_cnt_q == '0;

	// pin and clock configuration registers
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			dir_q  <= WRP_DIR_RST;
			pull_q <= WRP_PULL_RST;
			wsel_q <= '0;
			clk_q  <= WRP_CLK_RST;
		end else if (!core_rst_n_o) begin
			dir_q  <= WRP_DIR_RST;
			pull_q <= WRP_PULL_RST;
			wsel_q <= '0;
			clk_q  <= WRP_CLK_RST;
		end else if (wr) begin
			case (paddr_i)
				WRP_OFS_DIR:  dir_q  <= pwdata_i[7:0];
				WRP_OFS_PULL: pull_q <= pwdata_i[5:0];
				WRP_OFS_AUX:  wsel_q <= pwdata_i[WRP_AUX_SEL_LO +: 2];
				WRP_OFS_CLK:  clk_q  <= pwdata_i[4:0];
				default: ;
			endcase
		end
	end

	// power control; powerdown and idle requests clear on the edge that leaves the run state
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n)
			pctl_q <= '0;
		else if (!core_rst_n_o)
			pctl_q <= '0;
		else if (wr && paddr_i == WRP_OFS_PCTL)
			pctl_q <= pwdata_i[3:0];
		else if (state_q == WRP_ST_RUN && (pctl_q[WRP_PC_DOWN] || pctl_q[WRP_PC_IDLE])) begin
			pctl_q[WRP_PC_DOWN] <= 1'b0;
			pctl_q[WRP_PC_IDLE] <= 1'b0;
		end
	end
	assign down_req = pctl_q[WRP_PC_DOWN];

	// low-rate tick: wake sources are sampled at 1 kHz to save power
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n)
			lp_cnt_q <= '0;
		else if (lp_cnt_q == 14'(LP_DIV - 1))
			lp_cnt_q <= '0;
		else
			lp_cnt_q <= lp_cnt_q + 14'd1;
	end
	assign lp_tick = lp_cnt_q == 14'(LP_DIV - 1);

	// wake events; pins count only as input with pull bit clear, low level
	assign pin_wake = wake_mask(dir_q[WRP_DIR_WAKE_A], dir_q[WRP_DIR_WAKE_B], wsel_q)
	                  & dir_q[5:0] & ~pull_q & ~pin_s;
	always_comb begin
		ev               = '0;
		ev[WRP_WC_PIN]   = |pin_wake;
		ev[WRP_WC_CAR]   = car_s && pctl_q[WRP_PC_LFWAKE];
		ev[WRP_WC_PAT]   = pat_s && pctl_q[WRP_PC_LFWAKE];
		ev[WRP_WC_TMR]   = tmr_s;
		ev[WRP_WC_THERM] = state_q == WRP_ST_TSHUT && trel_s;
	end
	assign wake_ev = lp_tick && ((state_q == WRP_ST_PDOWN && |ev[3:0]) || ev[WRP_WC_THERM]);

	// device state machine
	always_comb begin
		state_d = state_q;
		case (state_q)
			WRP_ST_RUN: begin
				if (down_req)
					state_d = (pctl_q[WRP_PC_THERM] && !tok_s) ? WRP_ST_TSHUT : WRP_ST_PDOWN;
				else if (pctl_q[WRP_PC_IDLE])
					state_d = WRP_ST_IDLE;
			end
			WRP_ST_IDLE:  if (irq_s) state_d = WRP_ST_RUN;
			WRP_ST_PDOWN: if (wake_ev) state_d = WRP_ST_WAKE;
			WRP_ST_TSHUT: if (wake_ev) state_d = WRP_ST_WAKE;
			WRP_ST_WAKE:  if (boot_cnt_q == '0) state_d = WRP_ST_RUN;
			default:      state_d = WRP_ST_WAKE;
		endcase
	end

	// state register; a core reset restarts the boot sequence
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n)
			state_q <= WRP_ST_WAKE;
		else if (!core_rst_n_o)
			state_q <= WRP_ST_WAKE;
		else
			state_q <= state_d;
	end

	// boot interval counter, reloaded on every entry to wake
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n)
			boot_cnt_q <= 6'(WRP_BOOT_CYC);
		else if (!core_rst_n_o || state_q != WRP_ST_WAKE)
			boot_cnt_q <= 6'(WRP_BOOT_CYC);
		else if (boot_cnt_q != '0)
			boot_cnt_q <= boot_cnt_q - 6'd1;
	end

	// sticky wake cause, write one to clear; a new event wins over the clear
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n)
			cause_q <= '0;
		else if (!sys_rst_n_o)
			cause_q <= '0;
		else begin
			for (int i = 0; i < 5; i++) begin
				if (wake_ev && ev[i])
					cause_q[i] <= 1'b1;
				else if (wr && paddr_i == WRP_OFS_STAT && pwdata_i[WRP_STAT_CAUSE_LO + i])
					cause_q[i] <= 1'b0;
			end
		end
	end

	// power gating per state; detector and cpu clock follow the state
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			pwr_en_o     <= '0;
			cpu_clk_en_o <= 1'b0;
			hot_det_en_o <= 1'b0;
		end else begin
			pwr_en_o     <= pwr_map(state_q, pctl_q[WRP_PC_LFWAKE]);
			cpu_clk_en_o <= state_q == WRP_ST_RUN;
			hot_det_en_o <= pctl_q[WRP_PC_THERM] && (state_q == WRP_ST_RUN ||
			                state_q == WRP_ST_IDLE || state_q == WRP_ST_TSHUT);
		end
	end

	// oscillators: one of low or mid rc only, never both
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			lprc_en_o    <= 1'b0;
			midrc_en_o   <= 1'b1;
			sysclk_sel_o <= WRP_SRC_MID;
			sysclk_div_o <= '0;
		end else begin
			// mid rc serves controller and lf digital outside powerdown and thermal shutdown
			midrc_en_o <= !(state_q == WRP_ST_PDOWN || state_q == WRP_ST_TSHUT);
			lprc_en_o  <= state_q == WRP_ST_PDOWN || state_q == WRP_ST_TSHUT;
			sysclk_sel_o <= clk_q[1:0];
			// division only meaningful for the fast rc or crystal
			sysclk_div_o <= (clk_q[1:0] == WRP_SRC_HF || clk_q[1:0] == WRP_SRC_XO) ?
			                clk_q[WRP_CLK_DIV_LO +: 3] : 3'h0;
		end
	end
endmodule

// ---- shared/wrp_pkg.sv ----
// wrp_pkg: constants for the wake-up, reset and power control block
package wrp_pkg;
	// apb register byte offsets
	localparam logic [7:0] WRP_OFS_DIR   = 8'h00; // pin_direction_register
	localparam logic [7:0] WRP_OFS_PULL  = 8'h04; // pin_pull_register
	localparam logic [7:0] WRP_OFS_AUX   = 8'h08; // pin_data_aux_register
	localparam logic [7:0] WRP_OFS_PCTL  = 8'h0c; // power_control_register
	localparam logic [7:0] WRP_OFS_XCTL  = 8'h10; // extended_power_control_register
	localparam logic [7:0] WRP_OFS_CLK   = 8'h14; // clock control register
	localparam logic [7:0] WRP_OFS_STAT  = 8'h18; // state and wake cause register

	// field positions
	localparam int WRP_NPIN          = 6;
	localparam int WRP_DIR_WAKE_B    = 6;  // pin_wake_enable_b
	localparam int WRP_DIR_WAKE_A    = 7;  // pin_wake_enable_a
	localparam int WRP_AUX_SEL_LO    = 6;  // wake pin select [7:6]
	localparam int WRP_PC_DOWN       = 0;  // enter_powerdown_bit
	localparam int WRP_PC_THERM      = 1;  // thermal_shutdown_enable
	localparam int WRP_PC_LFWAKE     = 2;  // lf receiver wake enable
	localparam int WRP_PC_IDLE       = 3;  // cpu idle request
	localparam int WRP_EP_SWRST      = 0;  // software reset
	localparam int WRP_EP_TOK        = 1;  // temperature_ok_flag
	localparam int WRP_EP_MODE_LO    = 2;  // latched chip mode [3:2]
	localparam int WRP_CLK_DIV_LO    = 2;  // system_clock_divider [4:2]
	localparam int WRP_STAT_CAUSE_LO = 3;  // wake cause [7:3]

	// reset values
	localparam logic [7:0] WRP_DIR_RST  = 8'h00;
	localparam logic [5:0] WRP_PULL_RST = 6'h3f;
	localparam logic [4:0] WRP_CLK_RST  = 5'h01; // 39 kHz source, no division

	// system clock sources
	localparam logic [1:0] WRP_SRC_LP   = 2'h0;
	localparam logic [1:0] WRP_SRC_MID  = 2'h1;
	localparam logic [1:0] WRP_SRC_HF   = 2'h2;
	localparam logic [1:0] WRP_SRC_XO   = 2'h3;

	// power domain indices
	localparam int WRP_PWR_W    = 7;
	localparam int WRP_PD_CPU   = 0;
	localparam int WRP_PD_PERI  = 1;
	localparam int WRP_PD_MEM   = 2;
	localparam int WRP_PD_XO    = 3;
	localparam int WRP_PD_HFRC  = 4;
	localparam int WRP_PD_RF    = 5;
	localparam int WRP_PD_LF    = 6;

	// wake cause bits
	localparam int WRP_WC_PIN   = 0;
	localparam int WRP_WC_CAR   = 1;
	localparam int WRP_WC_PAT   = 2;
	localparam int WRP_WC_TMR   = 3;
	localparam int WRP_WC_THERM = 4;

	// timing
	localparam int WRP_CLK_HZ     = 10000000;
	localparam int WRP_LP_HZ      = 1000;
	localparam int WRP_LP_DIV     = WRP_CLK_HZ / WRP_LP_HZ;
	localparam int WRP_T_INI_US   = 1000;
	localparam int WRP_INI_CYC    = WRP_T_INI_US * (WRP_CLK_HZ / 1000000);
	localparam int WRP_T_SRST_NS  = 1600;
	localparam int WRP_SRST_CYC   = (WRP_T_SRST_NS * (WRP_CLK_HZ / 1000000) + 999) / 1000;
	localparam int WRP_T_BOOT_NS  = 3200;
	localparam int WRP_BOOT_CYC   = (WRP_T_BOOT_NS * (WRP_CLK_HZ / 1000000) + 999) / 1000;

	// device states
	typedef enum logic [2:0] {
		WRP_ST_RUN,
		WRP_ST_IDLE,
		WRP_ST_PDOWN,
		WRP_ST_TSHUT,
		WRP_ST_WAKE
	} wrp_state_e;
endpackage

// ---- src/wrp_sync2.sv ----
// wrp_sync2: two-flop level synchroniser, one lane per bit
`timescale 1ns/1ns
module wrp_sync2 #(
	parameter int W = 1
) (
	input  wire logic         clk_i,
	input  wire logic         nrst_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;

	// first stage is read by the second stage only
	genvar g;
	generate
		for (g = 0; g < W; g++) begin : g_lane
			always_ff @(posedge clk_i or negedge nrst_i) begin
				if (!nrst_i) begin
					meta_q[g] <= 1'b0;
					sync_q[g] <= 1'b0;
				end else begin
					meta_q[g] <= d_i[g];
					sync_q[g] <= meta_q[g];
				end
			end
		end
	endgenerate

	assign q_o = sync_q;
endmodule

// ---- verification/wrp_ctrl_sva.sv ----
// checker: port-level properties of the wake-up and power control block
`timescale 1ns/1ns
module wrp_ctrl_sva
	import wrp_pkg::*;
#(
	parameter int LP_DIV  = WRP_LP_DIV,
	parameter int INI_CYC = WRP_INI_CYC
) (
	input wire logic        clk_i,
	input wire logic        nrst_i,
	input wire logic        psel_i,
	input wire logic        penable_i,
	input wire logic        pwrite_i,
	input wire logic [7:0]  paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic        supply_ok_i,
	input wire logic        sys_rst_n_o,
	input wire logic        core_rst_n_o,
	input wire logic        cpu_clk_en_o,
	input wire logic        hot_det_en_o,
	input wire logic        lprc_en_o,
	input wire logic        midrc_en_o,
	input wire logic [1:0]  sysclk_sel_o,
	input wire logic [2:0]  sysclk_div_o,
	input wire logic [1:0]  chip_mode_o
);
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (!nrst_i);

	// write as the register file takes it; dropped while core is in reset
	logic wen;
	assign wen = psel_i && penable_i && pwrite_i && core_rst_n_o;

	a_osc_excl: assert property (!(lprc_en_o && midrc_en_o))
		else $error("low and mid rc enabled together");
	a_div_gate: assert property (sysclk_sel_o < 2'h2 |-> sysclk_div_o == 3'h0)
		else $error("divider applied to a slow rc");
	a_idle_gate: assert property (wen && paddr_i == WRP_OFS_PCTL && pwdata_i[3] &&
		!pwdata_i[0] && cpu_clk_en_o |-> ##[1:3] !cpu_clk_en_o)
		else $error("cpu clock kept in idle");
	a_det_on: assert property (wen && paddr_i == WRP_OFS_PCTL && pwdata_i[1] &&
		!pwdata_i[0] && !pwdata_i[3] |-> ##[1:2] hot_det_en_o)
		else $error("detector not enabled");
	a_swrst_pulse: assert property (wen && paddr_i == WRP_OFS_XCTL && pwdata_i[0]
		|-> ##[1:2] !core_rst_n_o [*8])
		else $error("software reset too short");
	a_mode_keep: assert property ($fell(core_rst_n_o) && sys_rst_n_o
		|=> $stable(chip_mode_o) [*8])
		else $error("mode changed by soft reset");
	a_supply_rst: assert property (!supply_ok_i |-> ##[0:4] !sys_rst_n_o)
		else $error("no reset on low supply");
	a_init_wait: assert property ($rose(sys_rst_n_o) |-> $past(supply_ok_i, INI_CYC))
		else $error("reset released too early");
endmodule

bind wrp_ctrl wrp_ctrl_sva #(.LP_DIV(LP_DIV), .INI_CYC(INI_CYC)) u_sva (
	.clk_i, .nrst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .supply_ok_i,
	.sys_rst_n_o, .core_rst_n_o, .cpu_clk_en_o, .hot_det_en_o, .lprc_en_o, .midrc_en_o,
	.sysclk_sel_o, .sysclk_div_o, .chip_mode_o
);

// ---- verification/wrp_fw_model.sv ----
// firmware model: apb master issuing register accesses
`timescale 1ns/1ns
module wrp_fw_model (
	input  wire logic        clk_i,
	output logic             psel_o,
	output logic             penable_o,
	output logic             pwrite_o,
	output logic [7:0]       paddr_o,
	output logic [31:0]      pwdata_o,
	input  wire logic [31:0] prdata_i,
	input  wire logic        pready_i,
	input  wire logic        pslverr_i
);
	// bus idle at time zero
	initial begin
		psel_o = 1'b0;
		penable_o = 1'b0;
		pwrite_o = 1'b0;
		paddr_o = 8'h00;
		pwdata_o = 32'h0;
	end

	// one transfer; data flipped afterwards so stale data never looks valid
	task automatic access(input logic w, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] q, output logic e);
		@(posedge clk_i);
		psel_o <= 1'b1;
		pwrite_o <= w;
		paddr_o <= a;
		pwdata_o <= d;
		@(posedge clk_i);
		penable_o <= 1'b1;
		// no cycle limit here: a hang is ended by the bench watchdog
		do begin
			@(posedge clk_i);
		end while (pready_i !== 1'b1);
		q = prdata_i;
		e = pslverr_i;
		psel_o <= 1'b0;
		penable_o <= 1'b0;
		pwdata_o <= ~d;
	endtask
endmodule

// ---- verification/wakeup_reset_power_control_test.sv ----
// testbench: wake-up, reset and power control block
`timescale 1ns/1ns
module wakeup_reset_power_control_test
	import wrp_pkg::*;
;
	logic        clk_i, nrst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, e;
	logic [7:0]  paddr_i;
	logic [31:0] pwdata_i, prdata_o, q;
	logic [5:0]  gpio_i;
	logic        supply_ok_i, temp_below_trip_i, temp_below_release_i, lf_carrier_i;
	logic        lf_pattern_i, periph_irq_i, sys_rst_n_o, core_rst_n_o, cpu_clk_en_o;
	logic        hot_det_en_o, lprc_en_o, midrc_en_o, timer_wake_i;
	logic [6:0]  pwr_en_o;
	logic [1:0]  sysclk_sel_o, chip_mode_o;
	logic [2:0]  sysclk_div_o;
	int          miscompares = 0;
	int          n_checks = 0;

	// short slow-tick and init counts keep the run brief
	wrp_ctrl #(.LP_DIV(20), .INI_CYC(10)) u_dut (
		.clk_i, .nrst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
		.pready_o, .pslverr_o, .gpio_i, .supply_ok_i, .temp_below_trip_i,
		.temp_below_release_i, .lf_carrier_i, .lf_pattern_i, .timer_wake_i,
		.periph_irq_i, .sys_rst_n_o, .core_rst_n_o, .pwr_en_o, .cpu_clk_en_o, .hot_det_en_o,
		.lprc_en_o, .midrc_en_o, .sysclk_sel_o, .sysclk_div_o, .chip_mode_o
	);
	wrp_fw_model u_fw (
		.clk_i, .psel_o(psel_i), .penable_o(penable_i), .pwrite_o(pwrite_i),
		.paddr_o(paddr_i), .pwdata_o(pwdata_i), .prdata_i(prdata_o), .pready_i(pready_o),
		.pslverr_i(pslverr_o)
	);

	// shared helpers
	task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
		n_checks++;
		if (g !== x) begin
			miscompares++;
			$display("BAD %s exp %h seen %h", nm, x, g);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		u_fw.access(1'b1, a, d, q, e);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		u_fw.access(1'b0, a, 32'h0, q, e);
		chk("rdata", x, q);
		chk("pslverr", a > WRP_OFS_STAT, e);
	endtask
	task automatic wst(input logic [2:0] s);
		int n;
		n = 0;
		do begin
			u_fw.access(1'b0, WRP_OFS_STAT, 32'h0, q, e);
			n++;
		end while (q[2:0] !== s && n < 300);
		chk("state", s, q[2:0]);
	endtask
	task automatic boot();
		int n;
		n = 0;
		while (core_rst_n_o !== 1'b1 && n < 500) begin
			@(posedge clk_i);
			n++;
		end
		wst(3'h0);
	endtask
	task automatic end_sim();
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// reset values, straps and an unmapped address
	task automatic t_reset();
		chk("midrc", 1'b1, midrc_en_o);
		chk("mode", 2'h2, chip_mode_o);
		rd(WRP_OFS_CLK, 32'h01);
		rd(WRP_OFS_PULL, 32'h3f);
		rd(WRP_OFS_DIR, 32'h0);
		rd(WRP_OFS_XCTL, 32'h0a);
		rd(8'h1c, 32'h0);
	endtask
	// every clock source, divider only on fast ones
	task automatic t_clk();
		for (int s = 0; s < 4; s++) begin
			wr(WRP_OFS_CLK, {27'h0, 3'h5, s[1:0]});
			cyc(3);
			chk("sel", s[1:0], sysclk_sel_o);
			chk("div", s > 1 ? 3'h5 : 3'h0, sysclk_div_o);
			chk("osc", 1'b0, lprc_en_o & midrc_en_o);
		end
		wr(WRP_OFS_CLK, 32'h01);
	endtask
	// pin 0 low is not selected; pin 1 low wakes
	task automatic t_pin();
		wr(WRP_OFS_DIR, 32'hbf);
		wr(WRP_OFS_PULL, 32'h0);
		wr(WRP_OFS_AUX, 32'h40);
		wr(WRP_OFS_PCTL, 32'h1);
		wst(3'h2);
		chk("cpu pwr", 1'b0, pwr_en_o[WRP_PD_CPU]);
		chk("lprc", 1'b1, lprc_en_o);
		chk("midrc", 1'b0, midrc_en_o);
		cyc(80);
		rd(WRP_OFS_STAT, 32'h02);
		gpio_i <= 6'h3c;
		wst(3'h0);
		gpio_i <= 6'h3f;
		rd(WRP_OFS_STAT, 32'h08);
		chk("cpu pwr", 1'b1, pwr_en_o[WRP_PD_CPU]);
		wr(WRP_OFS_STAT, 32'hf8);
	endtask
	// carrier, pattern, then timer wake from powerdown
	task automatic t_lf();
		for (int k = 0; k < 3; k++) begin
			wr(WRP_OFS_PCTL, 32'h5);
			wst(3'h2);
			chk("lf pwr", 1'b1, pwr_en_o[WRP_PD_LF]);
			lf_carrier_i <= (k == 0);
			lf_pattern_i <= (k == 1);
			timer_wake_i <= (k == 2);
			wst(3'h0);
			lf_carrier_i <= 1'b0;
			lf_pattern_i <= 1'b0;
			timer_wake_i <= 1'b0;
			rd(WRP_OFS_STAT, 32'h10 << k);
			wr(WRP_OFS_STAT, 32'hf8);
		end
		wr(WRP_OFS_PCTL, 32'h0);
	endtask
	// hot, shutdown held until cool, then wake
	task automatic t_therm();
		wr(WRP_OFS_PCTL, 32'h2);
		cyc(2);
		chk("hot det", 1'b1, hot_det_en_o);
		temp_below_trip_i <= 1'b0;
		temp_below_release_i <= 1'b0;
		cyc(4);
		rd(WRP_OFS_XCTL, 32'h08);
		wr(WRP_OFS_PCTL, 32'h3);
		wst(3'h3);
		cyc(80);
		rd(WRP_OFS_STAT, 32'h03);
		temp_below_trip_i <= 1'b1;
		temp_below_release_i <= 1'b1;
		wst(3'h0);
		rd(WRP_OFS_STAT, 32'h80);
		wr(WRP_OFS_STAT, 32'hf8);
		wr(WRP_OFS_PCTL, 32'h0);
		cyc(2);
		chk("hot det", 1'b0, hot_det_en_o);
	endtask
	// idle stops only the cpu clock; an interrupt resumes
	task automatic t_idle();
		wr(WRP_OFS_PCTL, 32'h8);
		cyc(3);
		chk("cpu clk", 1'b0, cpu_clk_en_o);
		chk("peri pwr", 1'b1, pwr_en_o[WRP_PD_PERI]);
		rd(WRP_OFS_STAT, 32'h01);
		periph_irq_i <= 1'b1;
		cyc(6);
		periph_irq_i <= 1'b0;
		chk("cpu clk", 1'b1, cpu_clk_en_o);
	endtask
	// soft reset keeps mode, clears registers and itself
	task automatic t_soft();
		wr(WRP_OFS_DIR, 32'h3f);
		wr(WRP_OFS_XCTL, 32'h1);
		cyc(2);
		chk("core rst", 1'b0, core_rst_n_o);
		chk("sys rst", 1'b1, sys_rst_n_o);
		boot();
		chk("mode", 2'h2, chip_mode_o);
		rd(WRP_OFS_DIR, 32'h0);
		rd(WRP_OFS_XCTL, 32'h0a);
	endtask
	// supply loss resets all and relatches new straps
	task automatic t_supply();
		wr(WRP_OFS_CLK, 32'h2);
		supply_ok_i <= 1'b0;
		cyc(6);
		chk("sys rst", 1'b0, sys_rst_n_o);
		gpio_i <= 6'h3d;
		cyc(20);
		chk("sys rst", 1'b0, sys_rst_n_o);
		supply_ok_i <= 1'b1;
		boot();
		chk("mode", 2'h1, chip_mode_o);
		rd(WRP_OFS_CLK, 32'h01);
	endtask

	// reset then scenarios in turn
	initial begin
		clk_i = 1'b0;
		nrst_i = 1'b0;
		supply_ok_i = 1'b1;
		temp_below_trip_i = 1'b1;
		temp_below_release_i = 1'b1;
		lf_carrier_i = 1'b0;
		lf_pattern_i = 1'b0;
		periph_irq_i = 1'b0;
		timer_wake_i = 1'b0;
		gpio_i = 6'h3e;
		cyc(4);
		nrst_i <= 1'b1;
		boot();
		t_reset();
		t_clk();
		t_pin();
		t_lf();
		t_therm();
		t_idle();
		t_soft();
		t_supply();
		end_sim();
	end
	always #50 clk_i = ~clk_i;
	// watchdog, far beyond the roughly one thousand cycles needed
	initial begin
		cyc(30000);
		miscompares++;
		end_sim();
	end
endmodule
